/* bench/fpec_array_model.sv */
// Flash array stand-in: presents an erase address while erasing.
// Assumes the bench chooses the target address.
`timescale 1ns/100ps
module fpec_array_model (
	input wire logic ref_clk_i,
	input wire fpec_pkg::fpec_mode_t mode_i,
	input wire logic [16:0] target_i,
	output logic [16:0] erase_addr_o
);
	// Outside an erase the bus shows the inverse target, so a stale address never looks valid.
	always_ff @(posedge ref_clk_i) begin
		erase_addr_o <= mode_i.erase_go ? target_i : ~target_i;
	end
endmodule

/* bench/fpec_ctrl_asserts.sv */
// Port checker for fpec_ctrl.
// Assumes the bind below attaches it to every fpec_ctrl instance.
`timescale 1ns/100ps
module fpec_ctrl_asserts #(
	parameter int ADDR_W = 4
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic hw_program_gate_i,
	input wire logic [2:0] op_mode_i,
	input wire logic hw_standby_i,
	input wire logic sw_standby_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic reg_rd_i,
	input wire logic [7:0] reg_rdata_o,
	input wire fpec_pkg::fpec_mode_t mode_o,
	input wire logic [7:0] block_select_bits_o
);
	default clocking cb @(posedge ref_clk_i);
	endclocking
	default disable iff (!rst_b_i);
	sequence s_rd_off;
		reg_rd_i && (op_mode_i == 3'h1 || op_mode_i == 3'h3);
	endsequence
	sequence s_rd_blk6;
		reg_rd_i && op_mode_i == 3'h6 && reg_addr_i == fpec_pkg::OFS_BLOCK_SEL;
	endsequence
	chk_rd_idle: assert property (!reg_rd_i |=> reg_rdata_o == 8'h00)
		else $error("read data not idle");
	chk_hw_mirror: assert property (reg_rd_i && reg_addr_i == fpec_pkg::OFS_MODE_CTRL
		&& op_mode_i[2] && op_mode_i[0] |=> reg_rdata_o[7] == $past(hw_program_gate_i))
		else $error("bit 7 does not follow pin");
	chk_flash_off: assert property (s_rd_off |=> reg_rdata_o == 8'h00)
		else $error("read with flash off not zero");
	chk_blk_ro: assert property (s_rd_blk6 |=> reg_rdata_o == 8'h00)
		else $error("block select read in mode 6 not zero");
	chk_pin_clear: assert property (!hw_program_gate_i |=> mode_o == 7'h00
		&& block_select_bits_o == 8'h00) else $error("pin low did not clear");
	chk_stby_clear: assert property (hw_standby_i || sw_standby_i |=> mode_o == 7'h00
		&& block_select_bits_o == 8'h00) else $error("standby did not clear");
	chk_sw_gate: assert property ($rose(mode_o.sw_gate) |-> $past(hw_program_gate_i))
		else $error("software gate set with pin low");
	chk_setup_gate: assert property ($rose(mode_o.erase_setup) || $rose(mode_o.prog_setup)
		|| $rose(mode_o.erase_verify) || $rose(mode_o.prog_verify) |-> $past(mode_o.sw_gate))
		else $error("setup or verify set without gate");
	chk_erase_go: assert property ($rose(mode_o.erase_go) |-> $past(mode_o.erase_setup))
		else $error("erase go without setup");
	chk_prog_go: assert property ($rose(mode_o.prog_go) |-> $past(mode_o.prog_setup))
		else $error("program go without setup");
	chk_blk_gate: assert property (|(block_select_bits_o & ~$past(block_select_bits_o))
		|-> $past(mode_o.sw_gate)) else $error("block set without gate");
endmodule
bind fpec_ctrl fpec_ctrl_asserts #(.ADDR_W(ADDR_W)) u_chk (.ref_clk_i, .rst_b_i,
	.hw_program_gate_i, .op_mode_i, .hw_standby_i, .sw_standby_i, .reg_addr_i,
	.reg_rd_i, .reg_rdata_o, .mode_o, .block_select_bits_o);

/* bench/fpec_ctrl_tb.sv */
// Self-checking bench for fpec_ctrl with a flash array stand-in.
// Assumes the checker binds itself to the design.
`timescale 1ns/100ps
module fpec_ctrl_tb;
	localparam logic [3:0] MC = fpec_pkg::OFS_MODE_CTRL;
	localparam logic [3:0] BS = fpec_pkg::OFS_BLOCK_SEL;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	logic pin = 1'b1;
	logic hs = 1'b0;
	logic ss = 1'b0;
	logic wr = 1'b0;
	logic rd = 1'b0;
	logic [2:0] opm = 3'h7;
	logic [3:0] addr = 4'h0;
	logic [7:0] wd = 8'h00;
	logic [7:0] rdata;
	logic [7:0] blk;
	logic [16:0] tgt = 17'h00000;
	logic [16:0] ea;
	logic allow;
	fpec_pkg::fpec_mode_t mode;
	int n_errors = 0;
	int check_count = 0;
	int cyc = 0;
	initial forever #2 clk = ~clk;
	fpec_ctrl DUT (.ref_clk_i(clk), .rst_b_i(rst_b), .hw_program_gate_i(pin), .op_mode_i(opm),
		.hw_standby_i(hs), .sw_standby_i(ss), .reg_addr_i(addr), .reg_wdata_i(wd),
		.reg_wr_i(wr), .reg_rd_i(rd), .erase_addr_i(ea), .reg_rdata_o(rdata),
		.mode_o(mode), .block_select_bits_o(blk), .erase_allowed_o(allow));
	fpec_array_model u_arr (.ref_clk_i(clk), .mode_i(mode), .target_i(tgt), .erase_addr_o(ea));
	task automatic chk(input logic [7:0] got, input logic [7:0] exp);
		check_count++;
		if (got !== exp) begin
			n_errors++;
			$display("CHECK FAILED t=%0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr8(input logic [3:0] a, input logic [7:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wd <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd8(input logic [3:0] a, input logic [7:0] exp);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1 chk(rdata, exp);
	endtask
	task automatic pins(input logic p, input logic [2:0] m);
		@(posedge clk);
		pin <= p;
		opm <= m;
		@(posedge clk);
	endtask
	task automatic t_program();
		wr8(MC, 8'h01);
		rd8(MC, 8'h80);
		wr8(MC, 8'h40);
		wr8(MC, 8'h41);
		rd8(MC, 8'hc0);
		wr8(MC, 8'h50);
		wr8(MC, 8'h51);
		rd8(MC, 8'hd1);
		chk({1'b0, mode}, 8'h45);
		wr8(MC, 8'h50);
		wr8(MC, 8'h40);
		wr8(MC, 8'h00);
		rd8(MC, 8'h80);
	endtask
	task automatic t_erase();
		logic [16:0] a[4] = '{17'h07fff, 17'h08000, 17'h01000, 17'h00fff};
		logic e[4] = '{1'b1, 1'b0, 1'b1, 1'b0};
		wr8(BS, 8'h10);
		rd8(BS, 8'h00);
		wr8(MC, 8'h40);
		wr8(BS, 8'h10);
		wr8(MC, 8'h42);
		rd8(MC, 8'hc0);
		wr8(MC, 8'h60);
		wr8(MC, 8'h62);
		rd8(MC, 8'he2);
		for (int i = 0; i < 4; i++) begin
			tgt <= a[i];
			repeat (3) @(posedge clk);
			#1 chk({7'h00, allow}, {7'h00, e[i]});
		end
		wr8(MC, 8'h60);
		wr8(MC, 8'h40);
		rd8(BS, 8'h10);
		wr8(MC, 8'h00);
		rd8(BS, 8'h00);
	endtask
	task automatic t_verify();
		wr8(MC, 8'h40);
		wr8(MC, 8'h48);
		rd8(MC, 8'hc8);
		wr8(MC, 8'h44);
		rd8(MC, 8'hc4);
		wr8(MC, 8'h40);
		rd8(MC, 8'hc0);
	endtask
	task automatic t_standby();
		for (int i = 0; i < 3; i++) begin
			wr8(BS, 8'h01);
			@(posedge clk);
			hs <= (i == 0);
			ss <= (i == 1);
			rst_b <= (i != 2);
			@(posedge clk);
			hs <= 1'b0;
			ss <= 1'b0;
			rst_b <= 1'b1;
			rd8(MC, 8'h80);
			rd8(BS, 8'h00);
			wr8(MC, 8'h40);
		end
	endtask
	task automatic t_modes();
		pins(1'b0, 3'h7);
		rd8(MC, 8'h00);
		wr8(MC, 8'h40);
		#1 chk({1'b0, mode}, 8'h00);
		pins(1'b1, 3'h6);
		wr8(MC, 8'h40);
		#1 chk({1'b0, mode}, 8'h00);
		rd8(BS, 8'h00);
		pins(1'b1, 3'h1);
		wr8(MC, 8'h40);
		#1 chk({1'b0, mode}, 8'h00);
		rd8(MC, 8'h00);
		rd8(4'h5, 8'h00);
		pins(1'b1, 3'h7);
	endtask
	task automatic summarize();
		$display("errors %0d checks %0d", n_errors, check_count);
		if (n_errors == 0 && check_count > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask
	// The ceiling is about twenty times the length of the whole sequence.
	always @(posedge clk) begin
		cyc++;
		if (cyc == 3000) begin
			n_errors++;
			summarize();
		end
	end
	initial begin
		repeat (16) @(posedge clk);
		rst_b <= 1'b1;
		rd8(MC, 8'h80);
		t_program();
		t_erase();
		t_verify();
		t_standby();
		t_modes();
		summarize();
	end
endmodule

/* verilog/fpec_block_map.sv */
// Erase block decoder: maps an array address to its one-hot block and
// tells whether the selected block set allows erasing that address.
// Assumes addresses inside the flash array; purely combinational.
`timescale 1ns/100ps

module fpec_block_map #(
	parameter int ADDR_W = fpec_pkg::ARRAY_ADDR_W
) (
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [7:0] block_select_bits_i,
	output logic [7:0] block_hit_o,
	output logic erasable_o
);

	always_comb begin
		block_hit_o = 8'h00;
		if (addr_i >= fpec_pkg::BLK7_BASE) begin
			block_hit_o[7] = 1'b1;
		end else if (addr_i >= fpec_pkg::BLK6_BASE) begin
			block_hit_o[6] = 1'b1;
		end else if (addr_i >= fpec_pkg::BLK5_BASE) begin
			block_hit_o[5] = 1'b1;
		end else if (addr_i >= fpec_pkg::BLK4_BASE) begin
			block_hit_o[4] = 1'b1;
		end else if (addr_i >= fpec_pkg::BLK3_BASE) begin
			block_hit_o[3] = 1'b1;
		end else if (addr_i >= fpec_pkg::BLK2_BASE) begin
			block_hit_o[2] = 1'b1;
		end else if (addr_i >= fpec_pkg::BLK1_BASE) begin
			block_hit_o[1] = 1'b1;
		end else begin
			block_hit_o[0] = 1'b1;
		end
	end

	// Unselected blocks stay protected.
	assign erasable_o = |(block_hit_o & block_select_bits_i);

endmodule

/* verilog/fpec_ctrl.sv */
// Flash program/erase control registers and mode sequencing.
// Assumes a byte register port with one-cycle strobes and read data in the
// following cycle, mode pins and standby levels synchronous to ref_clk_i.
//
// Contract
// - Mode-control bit 7 mirrors the write-enable pin, read-only.
// - Mode-control initial value is 80 with pin high, 00 with pin low.
// - Mode-control returns to initial value on reset and either standby.
// - Software gate settable only with pin high; clear disables program and erase (here it only clears block select and locks the other bits as written).
// - Setup and verify bits writable only when pin and software gate are 1.
// - Erase-go writable only when pin, software gate and erase-setup are 1.
// - Program-go writable only when pin, software gate and program-setup are 1.
// - Program mode: software gate, then program-setup, then program-go.
// - Erase mode: software gate, then erase-setup, then erase-go.
// - In single-chip normal mode no mode-control bit can be set.
// - With on-chip flash disabled mode-control reads 00, writes ignored.
// - Block select clears on reset, standby, pin low, or software gate 0.
// - Each set block-select bit makes its block erasable; others protected.
// - Block-select bits not settable until software gate is 1.
// - Block select reads zero, read-only, in modes 1-4 and 6.
// - Blocks 0-3 are 1 kbyte, block 4 to 07fff, 5-7 32 kbytes.
`timescale 1ns/100ps

module fpec_ctrl #(
	parameter int ADDR_W = fpec_pkg::ADDR_W,
	parameter int ARRAY_ADDR_W = fpec_pkg::ARRAY_ADDR_W
) (
	input wire logic ref_clk_i,
	input wire logic rst_b_i,
	input wire logic hw_program_gate_i,
	input wire logic [2:0] op_mode_i,
	input wire logic hw_standby_i,
	input wire logic sw_standby_i,
	input wire logic [ADDR_W-1:0] reg_addr_i,
	input wire logic [7:0] reg_wdata_i,
	input wire logic reg_wr_i,
	input wire logic reg_rd_i,
	input wire logic [ARRAY_ADDR_W-1:0] erase_addr_i,
	output logic [7:0] reg_rdata_o,
	output fpec_pkg::fpec_mode_t mode_o,
	output logic [7:0] block_select_bits_o,
	output logic erase_allowed_o
);

	fpec_pkg::fpec_mode_t mode_reg;
	fpec_pkg::fpec_mode_t mode_next;
	logic [7:0] block_sel_reg;
	logic [7:0] block_sel_next;
	logic [7:0] rdata_reg;
	logic [7:0] rdata_next;
	logic erase_allowed_reg;
	logic erasable;
	logic flash_on;
	logic block_rw;
	logic pin_ok;
	logic gate_ok;
	logic standby;
	logic wr_mode;
	logic wr_block;

	function automatic logic [7:0] mode_image(input fpec_pkg::fpec_mode_t m, input logic pin);
		logic [7:0] v;
		v = 8'h00;
		v[fpec_pkg::BIT_HW_GATE] = pin;
		v[fpec_pkg::BIT_SW_GATE] = m.sw_gate;
		v[fpec_pkg::BIT_ERASE_SETUP] = m.erase_setup;
		v[fpec_pkg::BIT_PROG_SETUP] = m.prog_setup;
		v[fpec_pkg::BIT_ERASE_VERIFY] = m.erase_verify;
		v[fpec_pkg::BIT_PROG_VERIFY] = m.prog_verify;
		v[fpec_pkg::BIT_ERASE_GO] = m.erase_go;
		v[fpec_pkg::BIT_PROG_GO] = m.prog_go;
		return v;
	endfunction

	// On-chip flash is enabled only in modes 5, 6 and 7.
	assign flash_on = (op_mode_i == fpec_pkg::OPMODE_5) ||
		(op_mode_i == fpec_pkg::OPMODE_6) || (op_mode_i == fpec_pkg::OPMODE_7);
	assign block_rw = (op_mode_i == fpec_pkg::OPMODE_5) ||
		(op_mode_i == fpec_pkg::OPMODE_7);
	// The pin must be held low in mode 6; gating here keeps bits clear even if it is not.
	assign pin_ok = hw_program_gate_i && (op_mode_i != fpec_pkg::OPMODE_6);
	assign gate_ok = pin_ok && mode_reg.sw_gate;
	assign standby = hw_standby_i || sw_standby_i;
	assign wr_mode = reg_wr_i && (reg_addr_i == fpec_pkg::OFS_MODE_CTRL) && flash_on;
	assign wr_block = reg_wr_i && (reg_addr_i == fpec_pkg::OFS_BLOCK_SEL) && block_rw;

	// Each bit is judged on its own enabling condition so a refused bit keeps its value.
	always_comb begin
		mode_next = mode_reg;
		if (!pin_ok) begin
			// Dropping the pin clears the whole sequence at once.
			mode_next = '0;
		end else if (wr_mode) begin
			mode_next.sw_gate = reg_wdata_i[fpec_pkg::BIT_SW_GATE];
			if (mode_reg.sw_gate) begin
				mode_next.erase_setup = reg_wdata_i[fpec_pkg::BIT_ERASE_SETUP];
				mode_next.prog_setup = reg_wdata_i[fpec_pkg::BIT_PROG_SETUP];
				mode_next.erase_verify = reg_wdata_i[fpec_pkg::BIT_ERASE_VERIFY];
				mode_next.prog_verify = reg_wdata_i[fpec_pkg::BIT_PROG_VERIFY];
			end
			if (mode_reg.sw_gate && mode_reg.erase_setup) begin
				mode_next.erase_go = reg_wdata_i[fpec_pkg::BIT_ERASE_GO];
			end
			if (mode_reg.sw_gate && mode_reg.prog_setup) begin
				mode_next.prog_go = reg_wdata_i[fpec_pkg::BIT_PROG_GO];
			end
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			mode_reg <= '0;
		end else if (standby) begin
			mode_reg <= '0;
		end else begin
			mode_reg <= mode_next;
		end
	end

	always_comb begin
		block_sel_next = block_sel_reg;
		if (!gate_ok || !block_rw) begin
			block_sel_next = fpec_pkg::BLOCK_SEL_INIT;
		end else if (wr_block) begin
			block_sel_next = reg_wdata_i;
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			block_sel_reg <= fpec_pkg::BLOCK_SEL_INIT;
		end else if (standby) begin
			block_sel_reg <= fpec_pkg::BLOCK_SEL_INIT;
		end else begin
			block_sel_reg <= block_sel_next;
		end
	end

	// Read data are captured so they stand exactly one cycle after the strobe.
	always_comb begin
		rdata_next = fpec_pkg::READ_ZERO;
		if (reg_rd_i) begin
			case (reg_addr_i)
				fpec_pkg::OFS_MODE_CTRL: begin
					if (flash_on) begin
						rdata_next = mode_image(mode_reg, hw_program_gate_i);
					end
				end
				fpec_pkg::OFS_BLOCK_SEL: begin
					if (block_rw) begin
						rdata_next = block_sel_reg;
					end
				end
				default: begin
					rdata_next = fpec_pkg::READ_ZERO;
				end
			endcase
		end
	end

	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			rdata_reg <= fpec_pkg::READ_ZERO;
		end else begin
			rdata_reg <= rdata_next;
		end
	end

	fpec_block_map #(
		.ADDR_W(ARRAY_ADDR_W)
	) u_block_map (
		.addr_i(erase_addr_i),
		.block_select_bits_i(block_sel_reg),
		.block_hit_o(),
		.erasable_o(erasable)
	);

	// Registered so every output comes from a flip-flop; one cycle of latency.
	always_ff @(posedge ref_clk_i or negedge rst_b_i) begin
		if (!rst_b_i) begin
			erase_allowed_reg <= 1'b0;
		end else begin
			erase_allowed_reg <= erasable && mode_reg.erase_go;
		end
	end

	assign reg_rdata_o = rdata_reg;
	assign mode_o = mode_reg;
	assign block_select_bits_o = block_sel_reg;
	assign erase_allowed_o = erase_allowed_reg;

endmodule

/* verilog/fpec_pkg.sv */
// Package for the flash program/erase control block: register offsets,
// field positions, reset values, operating modes and the erase block map.
// Assumes a byte-wide register port decoded on the low address bits.
package fpec_pkg;

	localparam int ADDR_W = 4;
	localparam int DATA_W = 8;
	localparam int ARRAY_ADDR_W = 17;

	// Register offsets, low address bits of the flash control area.
	localparam logic [ADDR_W-1:0] OFS_MODE_CTRL = 4'h0;
	localparam logic [ADDR_W-1:0] OFS_BLOCK_SEL = 4'h2;

	// Bit positions within the mode-control register.
	localparam int BIT_HW_GATE = 7;
	localparam int BIT_SW_GATE = 6;
	localparam int BIT_ERASE_SETUP = 5;
	localparam int BIT_PROG_SETUP = 4;
	localparam int BIT_ERASE_VERIFY = 3;
	localparam int BIT_PROG_VERIFY = 2;
	localparam int BIT_ERASE_GO = 1;
	localparam int BIT_PROG_GO = 0;

	localparam logic [DATA_W-1:0] MODE_CTRL_INIT_HI = 8'h80;
	localparam logic [DATA_W-1:0] MODE_CTRL_INIT_LO = 8'h00;
	localparam logic [DATA_W-1:0] BLOCK_SEL_INIT = 8'h00;
	localparam logic [DATA_W-1:0] READ_ZERO = 8'h00;

	// Operating mode pin encodings.
	localparam logic [2:0] OPMODE_5 = 3'h5;
	localparam logic [2:0] OPMODE_6 = 3'h6;
	localparam logic [2:0] OPMODE_7 = 3'h7;

	// Erase block map: first address of blocks 1-7, ascending; block 0 starts at 0.
	localparam logic [ARRAY_ADDR_W-1:0] BLK1_BASE = 17'h00400;
	localparam logic [ARRAY_ADDR_W-1:0] BLK2_BASE = 17'h00800;
	localparam logic [ARRAY_ADDR_W-1:0] BLK3_BASE = 17'h00c00;
	localparam logic [ARRAY_ADDR_W-1:0] BLK4_BASE = 17'h01000;
	localparam logic [ARRAY_ADDR_W-1:0] BLK5_BASE = 17'h08000;
	localparam logic [ARRAY_ADDR_W-1:0] BLK6_BASE = 17'h10000;
	localparam logic [ARRAY_ADDR_W-1:0] BLK7_BASE = 17'h18000;

	// Mode outputs driven toward the flash array.
	typedef struct packed {
		logic prog_go;
		logic erase_go;
		logic prog_verify;
		logic erase_verify;
		logic prog_setup;
		logic erase_setup;
		logic sw_gate;
	} fpec_mode_t;

endpackage
